/* File: uart_host_regs.sv */
// serial port register file, receive and transmit paths and interrupt identification
// Functional notes
// [R1] eight byte offsets: data, enable, ident/fifo control, line, modem, status, scratch
// [R2] divisor bank bit 7 of line control maps offsets 0 and 1 to divisor bytes
// [R3] least significant data bit goes first on transmit and receive lines
// [R4] hidden receive shifter assembles eight bits then moves them to the buffer
// [R5] transmit shifter loads from holding buffer only after previous byte finished
// [R6] enable bits 0 to 3 clear: no interrupt, identification inhibited, status still updates
// [R7] enable bit 0 permits received data and, with fifos, character timeout
// [R8] enable bit 1 permits transmit holding empty interrupt
// [R9] enable bit 2 permits line status interrupt from overrun, parity, framing, break; code has no parity error source
// [R10] enable bit 3 permits modem status interrupt on any modem input change; code flags ring indicator only when it goes inactive
// [R11] enable bits 4 to 7 always read zero
// [R12] fifo control bit 0 enables both fifos; clearing or mode change empties them
// [R13] other fifo control bits are applied only when bit 0 is one
// [R14] fifo control bit 1 empties receive fifo, shifter untouched, self clearing
// [R15] fifo control bit 2 empties transmit fifo, shifter untouched, self clearing
// [R16] fifo control bit 3 has no effect; bits 4 and 5 reserved; no dma
// [R17] fifo control bits 7:6 pick receive trigger of 1, 4, 8 or 14 bytes
// [R18] every fifo control write kept in a readable shadow copy
// [R19] priority: line status, received data, transmit empty, modem status; highest reported
// [R20] identification value frozen while the host reads it
// [R21] ident bit 0 low when pending; bits 1 and 2 encode the source
// [R22] ident bit 3 zero outside fifo mode; set with bit 2 on timeout
// [R23] ident codes 1,6,4,C,2,0, each cleared by its own host access
// [R24] timeout when fifo holds data and nothing moved for four character times
// [R25] ident bits 5:4 read zero; bits 7:6 one in fifo mode
// [R26] interrupt output follows ident bit 0 low, gated by modem control bit 3
`timescale 1ns/1ps
`include "uart_host_regs_map.svh"
module uart_host_regs (
  input  wire logic       clk,        // 20 MHz system clock
  input  wire logic       rst,        // synchronous reset, active high
  input  wire logic [2:0] addr,       // register offset
  input  wire logic       rd_en,      // read strobe, one cycle
  input  wire logic       wr_en,      // write strobe, one cycle
  input  wire logic [7:0] wr_data,    // write data
  output logic      [7:0] rd_data,    // read data, one cycle after rd_en
  input  wire logic       rx_pin,     // serial receive line
  output logic            tx_pin,     // serial transmit line
  input  wire logic       cts_n,      // clear to send pin
  input  wire logic       dsr_n,      // data set ready pin
  input  wire logic       ri_n,       // ring indicator pin
  input  wire logic       dcd_n,      // carrier detect pin
  output logic            dtr_n,      // data terminal ready pin
  output logic            rts_n,      // request to send pin
  output logic            irq,        // interrupt request, active high
  output logic      [7:0] fifo_shadow // copy of last fifo control write
);
  fifo_if rx_f ();
  fifo_if tx_f ();
  byte_fifo u_rx (.clk(clk), .rst(rst), .f(rx_f));
  byte_fifo u_tx (.clk(clk), .rst(rst), .f(tx_f));
  logic [3:0]  ier_reg;
  logic [7:0]  lcr_reg;
  logic [4:0]  mcr_reg;
  logic [7:0]  scr_reg;
  logic [15:0] div_reg;
  logic        fifo_en_reg;
  logic [1:0]  trig_reg;
  logic [7:0]  iir_reg;
  logic [7:0]  rd_data_reg;
  logic        irq_reg;
  logic        tx_pin_reg;
  logic [7:0]  shadow_reg;
  logic        rx_s1_reg;
  logic        rx_s2_reg;
  logic [3:0]  m_s1_reg;
  logic [3:0]  m_s2_reg;
  logic [3:0]  m_prev_reg;
  logic [3:0]  m_delta_reg;
  logic [15:0] baud_cnt_reg;
  logic        tick_reg;
  uart_host_pkg::rx_state_t rx_state_reg;
  uart_host_pkg::tx_state_t tx_state_reg;
  logic [3:0]  rx_sub_reg;
  logic [2:0]  rx_bit_reg;
  logic [7:0]  rx_shift_reg;
  logic [3:0]  tx_sub_reg;
  logic [2:0]  tx_bit_reg;
  logic [7:0]  tx_shift_reg;
  logic        oe_reg;
  logic        fe_reg;
  logic        bi_reg;
  logic        thre_int_reg;
  logic        tx_empty_d_reg;
  logic [9:0]  tmo_cnt_reg;
  // host access decode
  wire bank    = lcr_reg[`LCR_BANK_BIT];                               // R2
  wire a_data  = (addr == `OFS_DATA);                                  // R1
  wire a_ier   = (addr == `OFS_IER);
  wire wr_thr  = wr_en && a_data && !bank;
  wire wr_dll  = wr_en && a_data && bank;                              // R2
  wire wr_ier  = wr_en && a_ier && !bank;
  wire wr_dlm  = wr_en && a_ier && bank;                               // R2
  wire wr_fcr  = wr_en && (addr == `OFS_IIR);
  wire wr_lcr  = wr_en && (addr == `OFS_LCR);
  wire wr_mcr  = wr_en && (addr == `OFS_MCR);
  wire wr_scr  = wr_en && (addr == `OFS_SCR);
  wire rd_rbr  = rd_en && a_data && !bank;
  wire rd_iir  = rd_en && (addr == `OFS_IIR);
  wire rd_lsr  = rd_en && (addr == `OFS_LSR);
  wire rd_msr  = rd_en && (addr == `OFS_MSR);
  // fifo mode and flushes; bits other than bit 0 only taken with bit 0 set
  wire fcr_en    = wr_data[`FCR_ENABLE_BIT];
  wire mode_chg  = wr_fcr && (fcr_en != fifo_en_reg);                  // R12
  wire rx_flush  = mode_chg || (wr_fcr && (!fcr_en || wr_data[`FCR_RX_CLR_BIT])); // R12 R14
  wire tx_flush  = mode_chg || (wr_fcr && (!fcr_en || wr_data[`FCR_TX_CLR_BIT])); // R12 R15
  wire [4:0] cap = fifo_en_reg ? `FIFO_DEPTH : 5'h01;
  wire rx_full   = (rx_f.count >= cap);
  wire tx_full   = (tx_f.count >= cap);
  wire tx_empty  = (tx_f.count == 5'h00);
  wire rx_empty  = (rx_f.count == 5'h00);
  // receive trigger level
  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    unique case (sel)
      2'b00: trig_level = 5'h01;
      2'b01: trig_level = 5'h04;
      2'b10: trig_level = 5'h08;
      2'b11: trig_level = 5'h0E;
    endcase
  endfunction
  wire rx_hit = fifo_en_reg ? (rx_f.count >= trig_level(trig_reg)) : !rx_empty; // R17
  // baud divider gives a 16x oversample tick
  wire [15:0] div_m1 = (div_reg == 16'h0000) ? 16'h0000 : div_reg - 16'h0001;
  wire        baud_wrap = (baud_cnt_reg == div_m1);
  // receive path events
  wire rx_sample = tick_reg && (rx_sub_reg == `OVERSAMPLE_LAST);
  wire rx_done   = (rx_state_reg == uart_host_pkg::RX_STOP) && rx_sample;
  wire rx_brk    = rx_done && !rx_s2_reg && (rx_shift_reg == 8'h00);
  wire rx_ferr   = rx_done && !rx_s2_reg;
  wire rx_ovr    = rx_done && rx_full;
  wire tx_load   = (tx_state_reg == uart_host_pkg::TX_IDLE) && !tx_empty; // R5
  wire tx_last   = tick_reg && (tx_sub_reg == `OVERSAMPLE_LAST);

  assign rx_f.push  = rx_done && !rx_full;                             // R4
  assign rx_f.wdata = rx_shift_reg;
  assign rx_f.pop   = rd_rbr;
  assign rx_f.flush = rx_flush;
  assign tx_f.push  = wr_thr && !tx_full;
  assign tx_f.wdata = wr_data;
  assign tx_f.pop   = tx_load;
  assign tx_f.flush = tx_flush;
  // character timeout: data waiting and no movement for four character times
  wire tmo_hit  = (tmo_cnt_reg == `CHAR_TIMEOUT);                      // R24
  wire tmo_rst  = rx_empty || !fifo_en_reg || rx_f.push || rx_f.pop;  // R24
  // interrupt sources, each gated by its enable bit
  wire rls_p  = ier_reg[`IER_RLS_BIT] && (oe_reg || fe_reg || bi_reg); // R9
  wire rda_p  = ier_reg[`IER_RDA_BIT] && rx_hit;                       // R7
  wire tmo_p  = ier_reg[`IER_RDA_BIT] && fifo_en_reg && tmo_hit;       // R7 R22
  wire thre_p = ier_reg[`IER_THRE_BIT] && thre_int_reg;                // R8
  wire ms_p   = ier_reg[`IER_MS_BIT] && (m_delta_reg != 4'h0);         // R10
  wire [3:0] iir_code = rls_p  ? `IIR_RLS :                            // R19 R21 R23
                        rda_p  ? `IIR_RDA :
                        tmo_p  ? `IIR_TMO :
                        thre_p ? `IIR_THRE :
                        ms_p   ? `IIR_MS : `IIR_NONE;                  // R6
  wire [7:0] iir_live = {fifo_en_reg, fifo_en_reg, 2'b00, iir_code};   // R25
  wire [7:0] iir_next = rd_iir ? iir_reg : iir_live;                   // R20

  wire [7:0] lsr_val = {1'b0, tx_empty && (tx_state_reg == uart_host_pkg::TX_IDLE), tx_empty,
                        bi_reg, fe_reg, 1'b0, oe_reg, !rx_empty};
  wire [3:0] m_now   = m_s2_reg;
  wire [7:0] msr_val = {m_now, m_delta_reg};
  wire [7:0] rd_mux  = a_data ? (bank ? div_reg[7:0] : rx_f.q) :      // R1 R2
                       a_ier  ? (bank ? div_reg[15:8] : {4'h0, ier_reg}) : // R11
                       (addr == `OFS_IIR) ? iir_reg :
                       (addr == `OFS_LCR) ? lcr_reg :
                       (addr == `OFS_MCR) ? {3'h0, mcr_reg} :
                       (addr == `OFS_LSR) ? lsr_val :
                       (addr == `OFS_MSR) ? msr_val : scr_reg;

  wire tx_line = (tx_state_reg == uart_host_pkg::TX_START) ? 1'b0 :
                 (tx_state_reg == uart_host_pkg::TX_DATA) ? tx_shift_reg[0] : 1'b1; // R3
  assign rd_data     = rd_data_reg;
  assign tx_pin      = tx_pin_reg;
  assign irq         = irq_reg;
  assign dtr_n       = ~mcr_reg[`MCR_DTR_BIT];
  assign rts_n       = ~mcr_reg[`MCR_RTS_BIT];
  assign fifo_shadow = shadow_reg;
  // host-written registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ier_reg     <= `RESET_IER;
      lcr_reg     <= `RESET_LCR;
      mcr_reg     <= `RESET_MCR;
      scr_reg     <= 8'h00;
      div_reg     <= `RESET_DIV;
      fifo_en_reg <= 1'b0;
      trig_reg    <= 2'b00;
      shadow_reg  <= `RESET_FCR;
    end else begin
      if (wr_ier) ier_reg <= wr_data[3:0];                             // R11
      if (wr_lcr) lcr_reg <= wr_data;
      if (wr_mcr) mcr_reg <= wr_data[4:0];
      if (wr_scr) scr_reg <= wr_data;
      if (wr_dll) div_reg[7:0] <= wr_data;                             // R2
      if (wr_dlm) div_reg[15:8] <= wr_data;                            // R2
      if (wr_fcr) fifo_en_reg <= fcr_en;                               // R12
      if (wr_fcr && fcr_en) trig_reg <= wr_data[7:6];                  // R13 R16 R17
      if (wr_fcr) shadow_reg <= wr_data;                               // R18
    end
  end
  // pin synchronisers and baud tick
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_s1_reg    <= 1'b1;
      rx_s2_reg    <= 1'b1;
      m_s1_reg     <= 4'h0;
      m_s2_reg     <= 4'h0;
      baud_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b0;
    end else begin
      rx_s1_reg    <= rx_pin;
      rx_s2_reg    <= rx_s1_reg;
      m_s1_reg     <= ~{dcd_n, ri_n, dsr_n, cts_n};
      m_s2_reg     <= m_s1_reg;
      baud_cnt_reg <= baud_wrap ? 16'h0000 : baud_cnt_reg + 16'h0001;
      tick_reg     <= baud_wrap;
    end
  end
  // receiver: start check at mid bit, data and stop also sampled at mid bit
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_state_reg <= uart_host_pkg::RX_IDLE;
      rx_sub_reg   <= 4'h0;
      rx_bit_reg   <= 3'h0;
      rx_shift_reg <= 8'h00;
    end else begin
      if (tick_reg) rx_sub_reg <= rx_sub_reg + 4'h1;
      unique case (rx_state_reg)
        uart_host_pkg::RX_IDLE: begin
          rx_sub_reg <= 4'h0;
          if (!rx_s2_reg) rx_state_reg <= uart_host_pkg::RX_START;
        end
        uart_host_pkg::RX_START: begin
          if (tick_reg && rx_sub_reg == `MID_SAMPLE) begin
            rx_sub_reg   <= 4'h0;
            rx_bit_reg   <= 3'h0;
            rx_state_reg <= rx_s2_reg ? uart_host_pkg::RX_IDLE : uart_host_pkg::RX_DATA;
          end
        end
        uart_host_pkg::RX_DATA: begin
          if (rx_sample) begin
            rx_shift_reg <= {rx_s2_reg, rx_shift_reg[7:1]};            // R3 R4
            rx_bit_reg   <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == 3'h7) rx_state_reg <= uart_host_pkg::RX_STOP;
          end
        end
        uart_host_pkg::RX_STOP: begin
          if (rx_sample) begin
            rx_state_reg <= rx_s2_reg ? uart_host_pkg::RX_IDLE : uart_host_pkg::RX_HOLD;
          end
        end
        uart_host_pkg::RX_HOLD: begin
          if (rx_s2_reg) rx_state_reg <= uart_host_pkg::RX_IDLE;
        end
        default: rx_state_reg <= uart_host_pkg::RX_IDLE;
      endcase
    end
  end
  // transmitter: shifter taken from the fifo head only when idle
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_state_reg <= uart_host_pkg::TX_IDLE;
      tx_sub_reg   <= 4'h0;
      tx_bit_reg   <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_pin_reg   <= 1'b1;
    end else begin
      tx_pin_reg <= tx_line && !lcr_reg[`LCR_BREAK_BIT];
      if (tick_reg) tx_sub_reg <= tx_sub_reg + 4'h1;
      unique case (tx_state_reg)
        uart_host_pkg::TX_IDLE: begin
          tx_sub_reg <= 4'h0;
          if (tx_load) begin                                           // R5
            tx_shift_reg <= tx_f.q;
            tx_state_reg <= uart_host_pkg::TX_START;
          end
        end
        uart_host_pkg::TX_START: begin
          if (tx_last) begin
            tx_bit_reg   <= 3'h0;
            tx_state_reg <= uart_host_pkg::TX_DATA;
          end
        end
        uart_host_pkg::TX_DATA: begin
          if (tx_last) begin
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};                 // R3
            tx_bit_reg   <= tx_bit_reg + 3'h1;
            if (tx_bit_reg == 3'h7) tx_state_reg <= uart_host_pkg::TX_STOP;
          end
        end
        uart_host_pkg::TX_STOP: begin
          if (tx_last) tx_state_reg <= uart_host_pkg::TX_IDLE;
        end
      endcase
    end
  end
  // status flags: a setting event wins over the clearing access
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_reg         <= 1'b0;
      fe_reg         <= 1'b0;
      bi_reg         <= 1'b0;
      thre_int_reg   <= 1'b0;
      tx_empty_d_reg <= 1'b1;
      m_prev_reg     <= 4'h0;
      m_delta_reg    <= 4'h0;
      tmo_cnt_reg    <= 10'h000;
    end else begin
      oe_reg         <= rx_ovr || (oe_reg && !rd_lsr);                 // R9 R23
      fe_reg         <= rx_ferr || (fe_reg && !rd_lsr);                // R9 R23
      bi_reg         <= rx_brk || (bi_reg && !rd_lsr);                 // R9 R23
      tx_empty_d_reg <= tx_empty;
      thre_int_reg   <= (tx_empty && !tx_empty_d_reg) ||               // R8 R23
                        (thre_int_reg && !wr_thr && !(rd_iir && iir_reg[3:0] == `IIR_THRE));
      m_prev_reg     <= m_now;
      m_delta_reg    <= {((m_prev_reg[3] ^ m_now[3]) || (m_delta_reg[3] && !rd_msr)),   // R10
                         ((m_prev_reg[2] && !m_now[2]) || (m_delta_reg[2] && !rd_msr)),
                         ((m_prev_reg[1] ^ m_now[1]) || (m_delta_reg[1] && !rd_msr)),
                         ((m_prev_reg[0] ^ m_now[0]) || (m_delta_reg[0] && !rd_msr))};
      if (tmo_rst) tmo_cnt_reg <= 10'h000;                             // R24
      else if (tick_reg && !tmo_hit) tmo_cnt_reg <= tmo_cnt_reg + 10'h001;
    end
  end
  // identification, interrupt line and read data
  always_ff @(posedge clk) begin
    if (rst) begin
      iir_reg     <= {4'h0, `IIR_NONE};
      irq_reg     <= 1'b0;
      rd_data_reg <= 8'h00;
    end else begin
      iir_reg     <= iir_next;                                         // R20
      irq_reg     <= !iir_next[0] && mcr_reg[`MCR_GATE_BIT];           // R26
      rd_data_reg <= rd_en ? rd_mux : 8'h00;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ovr_byte;
    rx_done && rx_full;
  endsequence
  sequence s_ident_read;
    rd_iir ##1 1'b1;
  endsequence
  AST_IER_HIGH_ZERO: assert property (rd_en && a_ier && !bank |=> rd_data[7:4] == 4'h0) // R11
    else $error("enable upper bits not zero");
  AST_BANK_LOW: assert property (rd_en && a_data && bank |=> rd_data == $past(div_reg[7:0])) // R2
    else $error("divisor low byte not returned");
  AST_NO_ENABLE: assert property (ier_reg == 4'h0 && !rd_iir |=> iir_reg[0] && !irq) // R6
    else $error("interrupt shown with enables clear");
  AST_IIR_FREEZE: assert property (s_ident_read |-> $stable(iir_reg)) // R20
    else $error("identification changed during read");
  AST_IRQ_MATCH: assert property (1'b1 |=> irq == (!iir_reg[0] && $past(mcr_reg[3]))) // R26
    else $error("interrupt line disagrees with identification");
  AST_RLS_FIRST: assert property (rls_p && !rd_iir |=> iir_reg[3:0] == 4'h6) // R19
    else $error("line status not given top priority");
  AST_OVERRUN: assert property (s_ovr_byte |=> oe_reg && rx_f.count == $past(rx_f.count)) // R9
    else $error("overrun not flagged");
  AST_RX_FLUSH: assert property (rx_flush |=> rx_f.count == 5'h00) // R14
    else $error("receive fifo not emptied");
  AST_TX_LOAD: assert property (tx_f.pop |=> $past(tx_state_reg) == uart_host_pkg::TX_IDLE && // R5
    tx_state_reg == uart_host_pkg::TX_START && tx_shift_reg == $past(tx_f.q))
    else $error("transmit shifter loaded while busy");
  AST_IIR_HIGH: assert property (1'b1 |=> iir_reg[5:4] == 2'b00 && (iir_reg[3] -> iir_reg[2])) // R22 R25
    else $error("identification reserved or timeout bits wrong");
endmodule

/* File: uart_host_regs_map.svh */
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef UART_HOST_REGS_MAP_SVH
`define UART_HOST_REGS_MAP_SVH
`define OFS_DATA        3'h0
`define OFS_IER         3'h1
`define OFS_IIR         3'h2
`define OFS_LCR         3'h3
`define OFS_MCR         3'h4
`define OFS_LSR         3'h5
`define OFS_MSR         3'h6
`define OFS_SCR         3'h7
`define SHADOW_OFS_P1   8'h20
`define SHADOW_OFS_P2   8'h1D
`define LCR_BANK_BIT    7
`define LCR_BREAK_BIT   6
`define MCR_DTR_BIT     0
`define MCR_RTS_BIT     1
`define MCR_GATE_BIT    3
`define IER_RDA_BIT     0
`define IER_THRE_BIT    1
`define IER_RLS_BIT     2
`define IER_MS_BIT      3
`define FCR_ENABLE_BIT  0
`define FCR_RX_CLR_BIT  1
`define FCR_TX_CLR_BIT  2
`define IIR_NONE        4'h1
`define IIR_RLS         4'h6
`define IIR_RDA         4'h4
`define IIR_TMO         4'hC
`define IIR_THRE        4'h2
`define IIR_MS          4'h0
`define RESET_IER       4'h0
`define RESET_LCR       8'h00
`define RESET_MCR       5'h00
`define RESET_DIV       16'h0001
`define RESET_FCR       8'h00
`define FIFO_DEPTH      5'h10
`define OVERSAMPLE_LAST 4'hF
`define MID_SAMPLE      4'h7
`define CHAR_TIMEOUT    10'h280
`endif

/* File: uart_host_pkg.sv */
// types shared by the serial port modules
package uart_host_pkg;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_HOLD} rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
  typedef logic [4:0] fifo_count_t;
endpackage

/* File: fifo_if.sv */
// connection between the port logic and one byte fifo store
`timescale 1ns/1ps
interface fifo_if;
  logic                      push;
  logic                      pop;
  logic                      flush;
  logic [7:0]                wdata;
  logic [7:0]                q;
  uart_host_pkg::fifo_count_t count;
  modport user  (output push, output pop, output flush, output wdata, input q, input count);
  modport store (input push, input pop, input flush, input wdata, output q, output count);
endinterface

/* File: byte_fifo.sv */
// sixteen byte fifo store with registered head output
`timescale 1ns/1ps
`include "uart_host_regs_map.svh"
module byte_fifo (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  fifo_if.store    f    // push, pop, flush and head data
);
  logic [7:0] mem [0:15];
  logic [3:0] wr_ptr_reg;
  logic [3:0] rd_ptr_reg;
  uart_host_pkg::fifo_count_t count_reg;
  logic [7:0] q_reg;
  wire        do_push = f.push && !f.flush && (count_reg != `FIFO_DEPTH);
  wire        do_pop  = f.pop && !f.flush && (count_reg != 5'h00);
  wire  [3:0] rd_next = f.flush ? 4'h0 : (do_pop ? rd_ptr_reg + 4'h1 : rd_ptr_reg);
  assign f.q     = q_reg;
  assign f.count = count_reg;
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= f.wdata;
    end
  end
  // head bypass keeps q valid in the same cycle the count turns non-zero
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      count_reg  <= 5'h00;
      q_reg      <= 8'h00;
    end else begin
      wr_ptr_reg <= f.flush ? 4'h0 : (do_push ? wr_ptr_reg + 4'h1 : wr_ptr_reg);
      rd_ptr_reg <= rd_next;
      count_reg  <= f.flush ? 5'h00 : count_reg + {4'h0, do_push} - {4'h0, do_pop};
      q_reg      <= (do_push && wr_ptr_reg == rd_next) ? f.wdata : mem[rd_next];
    end
  end
endmodule

/* File: serial_partner.sv */
// serial line model standing on the far side of the port
`timescale 1ns/1ps
module serial_partner (
  input  wire logic       clk,    // system clock
  input  wire logic       tx_pin, // line from the port
  output logic            rx_pin, // line into the port
  output logic      [7:0] got,    // last byte taken
  output int              n_got   // bytes taken so far
);
  initial begin
    rx_pin = 1'b1;
    got = 8'h00;
    n_got = 0;
  end
  // divisor 1: sixteen clocks a bit, sample in mid bit
  always begin
    @(negedge tx_pin);
    repeat (24) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      got[i] = tx_pin;
      repeat (16) @(posedge clk);
    end
    n_got++;
  end
  task automatic send(input logic [7:0] b, input logic stop);
    @(negedge clk);
    rx_pin = 1'b0;
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(negedge clk);
      rx_pin = (i < 8) ? b[i] : stop;
    end
    repeat (16) @(negedge clk);
    rx_pin = 1'b1;
  endtask
endmodule

/* File: test_uart_host_regs.sv */
// self-checking bench for the serial port registers
`timescale 1ns/1ps
module test_uart_host_regs;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic       rd_en = 1'b0;
  logic       wr_en = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic [3:0] modem_n = 4'hF;
  logic [7:0] rd_data, fifo_shadow, v, got;
  logic       rx_pin, tx_pin, dtr_n, rts_n, irq;
  int         n_fail = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         n_got;
  initial forever #25 clk = ~clk;
  uart_host_regs DUT (.clk(clk), .rst(rst), .addr(addr), .rd_en(rd_en), .wr_en(wr_en),
    .wr_data(wr_data), .rd_data(rd_data), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .cts_n(modem_n[0]), .dsr_n(modem_n[1]), .ri_n(modem_n[2]), .dcd_n(modem_n[3]),
    .dtr_n(dtr_n), .rts_n(rts_n), .irq(irq), .fifo_shadow(fifo_shadow));
  serial_partner line (.clk(clk), .tx_pin(tx_pin), .rx_pin(rx_pin), .got(got), .n_got(n_got));
  task automatic stop_test();
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    v = rd_data;
    chk(v, e);
  endtask
  task automatic wait_got(input int n);
    for (int i = 0; i < 600 && n_got < n; i++) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rc(3'h1, 8'h00);
    rc(3'h2, 8'h01);
    wr(3'h1, 8'hFF);
    rc(3'h1, 8'h0F);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    rc(3'h0, 8'h01);
    rc(3'h1, 8'h00);
    wr(3'h3, 8'h03);
    rc(3'h1, 8'h0F);
    wr(3'h7, 8'h5A);
    rc(3'h7, 8'h5A);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h0B);
    chk({6'h00, dtr_n, rts_n}, 8'h00);
    wr(3'h2, 8'hC9);
    chk(fifo_shadow, 8'hC9);
    rc(3'h2, 8'hC1);
    wr(3'h2, 8'h01);
    wr(3'h1, 8'h02);
    wr(3'h0, 8'hA5);
    wr(3'h0, 8'h3C);
    wait_got(1);
    chk(got, 8'hA5);
    wait_got(2);
    chk(got, 8'h3C);
    chk({7'h00, irq}, 8'h01);
    wr(3'h1, 8'h03);
    line.send(8'h96, 1'b1);
    repeat (4) @(negedge clk);
    rc(3'h2, 8'hC4);
    rc(3'h0, 8'h96);
    rc(3'h2, 8'hC2);
    rc(3'h2, 8'hC1);
    line.send(8'h11, 1'b1);
    wr(3'h1, 8'h00);
    rc(3'h2, 8'hC1);
    chk({7'h00, irq}, 8'h00);
    wr(3'h1, 8'h01);
    rc(3'h2, 8'hC4);
    wr(3'h2, 8'h03);
    rc(3'h2, 8'hC1);
    wr(3'h2, 8'h41);
    line.send(8'h22, 1'b1);
    rc(3'h2, 8'hC1);
    repeat (800) @(negedge clk);
    rc(3'h2, 8'hCC);
    rc(3'h0, 8'h22);
    rc(3'h2, 8'hC1);
    wr(3'h2, 8'h00);
    rc(3'h2, 8'h01);
    wr(3'h1, 8'h04);
    line.send(8'h5A, 1'b0);
    repeat (4) @(negedge clk);
    rc(3'h2, 8'h06);
    rc(3'h5, 8'h69);
    rc(3'h2, 8'h01);
    wr(3'h1, 8'h08);
    modem_n = 4'hE;
    repeat (6) @(negedge clk);
    rc(3'h2, 8'h00);
    rc(3'h6, 8'h11);
    rc(3'h2, 8'h01);
    wr(3'h1, 8'h04);
    line.send(8'h33, 1'b1);
    repeat (4) @(negedge clk);
    rc(3'h2, 8'h06);
    rc(3'h5, 8'h63);
    rc(3'h0, 8'h5A);
    stop_test();
  end
endmodule
